// ==== core/pac_core.sv ====
/*
 * Control and status wrapper of a 12-bit pipelined converter: output
 * enable, power-down and wake, calibration sequencing, ready and
 * out-of-range flags, and a straight-binary result stream.
 * Assumes a free-running conversion clock and a sampled input word
 * from the analog front end, plus an APB master for the registers.
 */
// Overview of operation
// - Enable low drives data and flag outputs
// - Enable high floats all output buffers
// - Power-down high halts conversion, low power
// - Resume conversion within wake delay after power-down
// - Power-down corrupts pipeline; early results invalid
// - Ready high only when able to convert
// - Out-of-range outside ground to reference, inclusive
// - Result is 12-bit unsigned straight binary
// - Calibration lasts 4000 clock cycles
// - Calibrate at power-on and on request
// - One result per clock, fixed latency
`timescale 1ns/1ns
`default_nettype none
module pac_core
	import pac_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Pins from the host
	input  wire logic              output_enable_n,
	input  wire logic              power_down_request,
	input  wire logic              cal_request,
	// Sampled analog input, signed with guard bits
	input  wire logic signed [13:0] sample_in,
	input  wire logic [13:0]       ref_level,
	// Output pins, with their enables
	output logic [DATA_W-1:0]      data_out,
	output logic                   data_oe,
	output logic                   ready_out,
	output logic                   out_of_range,
	output logic                   flags_oe,
	// Buffered result stream
	output logic                   res_valid,
	input  wire logic              res_ready,
	output pac_word_t              res_word
);

	pac_state_t          state_ff, nxt_state;
	logic [11:0]         cnt_ff, nxt_cnt;
	logic [1:0]          calq_ff, nxt_calq;
	logic [PIPE_DEPTH-1:0] vpipe_ff, nxt_vpipe;
	pac_word_t           pipe_ff [PIPE_DEPTH];
	pac_word_t           nxt_pipe [PIPE_DEPTH];
	logic [31:0]         ctrl_ff, nxt_ctrl;
	logic [31:0]         prdata_ff, nxt_prdata;
	logic                pready_ff, nxt_pready;
	logic                pslverr_ff, nxt_pslverr;
	logic [DATA_W-1:0]   dout_ff, nxt_dout;
	logic                rdy_ff, nxt_rdy;
	logic                or_ff, nxt_or;
	logic                oe_ff, nxt_oe;
	pac_word_t           buf_ff [2];
	pac_word_t           nxt_buf [2];
	logic [1:0]          bcnt_ff, nxt_bcnt;
	logic                vld_ff, nxt_vld;
	logic                pd_req;
	logic                cal_req;
	logic                conv_en;
	logic                enc_or;
	logic [DATA_W-1:0]   enc_code;
	logic                in_push;
	logic                out_pop;
	logic                hdr_wr;
	logic                apb_acc;

	// Counters run from zero, so each ends one short
	localparam logic [11:0] CAL_LAST  = 12'(CAL_CYCLES - 1);
	localparam logic [11:0] WAKE_LAST = 12'(WAKE_CYCLES - 1);

	// Pin and register requests are or'ed together
	assign pd_req  = power_down_request | ctrl_ff[CTRL_PD_BIT];
	assign cal_req = cal_request | ctrl_ff[CTRL_CAL_BIT];
	assign conv_en = (state_ff == ST_RUN);

	// Out-of-range and straight-binary coding
	always_comb begin
		enc_or   = (sample_in < 0) ||
			($unsigned(sample_in) > ref_level);
		if (sample_in < 0)
			enc_code = '0;
		// A reference above full scale clips the code, never wraps
		else if (enc_or || sample_in[DATA_W+1:DATA_W] != 2'b00)
			enc_code = '1;
		else
			enc_code = sample_in[DATA_W-1:0];
	end

	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		// Saturating count: a held request starts one calibration
		nxt_calq  = cal_req ? ((calq_ff == 2'b11) ? calq_ff
			: 2'(calq_ff + 2'd1)) : 2'b00;
		case (state_ff)
			ST_CAL: begin
				// Calibration cannot be cut short by power-down
				if (cnt_ff == CAL_LAST) begin
					nxt_cnt   = '0;
					nxt_state = pd_req ? ST_PD : ST_RUN;
				end else begin
					nxt_cnt = 12'(cnt_ff + 12'd1);
				end
			end
			ST_RUN: begin
				if (pd_req) begin
					nxt_state = ST_PD;
				end else if (cal_req &&
					calq_ff == 2'(CAL_REQ_CYCLES - 1)) begin
					nxt_state = ST_CAL;
					nxt_cnt   = '0;
				end
			end
			ST_PD: begin
				nxt_cnt = '0;
				if (!pd_req)
					nxt_state = ST_WAKE;
			end
			ST_WAKE: begin
				// Power-down again restarts the wake count
				if (pd_req) begin
					nxt_state = ST_PD;
				end else if (cnt_ff == WAKE_LAST) begin
					nxt_state = ST_RUN;
					nxt_cnt   = '0;
				end else begin
					nxt_cnt = 12'(cnt_ff + 12'd1);
				end
			end
			default: nxt_state = ST_CAL;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_CAL;
			cnt_ff   <= '0;
			calq_ff  <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			calq_ff  <= nxt_calq;
		end
	end

	// Conversion pipeline
	always_comb begin
		nxt_vpipe = {vpipe_ff[PIPE_DEPTH-2:0], conv_en};
		nxt_pipe[0].code         = enc_code;
		nxt_pipe[0].out_of_range = enc_or;
		for (int i = 1; i < PIPE_DEPTH; i++)
			nxt_pipe[i] = pipe_ff[i-1];
		// Samples still shift while halted; only validity is lost
		if (!conv_en)
			nxt_vpipe = '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vpipe_ff <= '0;
			for (int i = 0; i < PIPE_DEPTH; i++)
				pipe_ff[i] <= '0;
		end else begin
			vpipe_ff <= nxt_vpipe;
			for (int i = 0; i < PIPE_DEPTH; i++)
				pipe_ff[i] <= nxt_pipe[i];
		end
	end

	// Pin outputs, all on one edge
	always_comb begin
		nxt_dout = pipe_ff[PIPE_DEPTH-1].code;
		nxt_or   = pipe_ff[PIPE_DEPTH-1].out_of_range;
		// Ready waits for a full pipeline of valid samples
		nxt_rdy  = conv_en && vpipe_ff[PIPE_DEPTH-1];
		nxt_oe   = !output_enable_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_ff <= '0;
			or_ff   <= 1'b0;
			rdy_ff  <= 1'b0;
			oe_ff   <= 1'b0;
		end else begin
			dout_ff <= nxt_dout;
			or_ff   <= nxt_or;
			rdy_ff  <= nxt_rdy;
			oe_ff   <= nxt_oe;
		end
	end

	assign data_out     = dout_ff;
	assign out_of_range = or_ff;
	assign ready_out    = rdy_ff;
	assign data_oe      = oe_ff;
	assign flags_oe     = oe_ff;

	// Two-entry result buffer; a stalled reader drops later words
	assign in_push = vpipe_ff[PIPE_DEPTH-1] && conv_en &&
		(bcnt_ff != 2'd2);
	assign out_pop = res_ready && (bcnt_ff != 2'd0);

	always_comb begin
		nxt_buf  = buf_ff;
		nxt_bcnt = bcnt_ff;
		if (out_pop) begin
			nxt_buf[0] = buf_ff[1];
			nxt_bcnt   = 2'(nxt_bcnt - 2'd1);
		end
		if (in_push) begin
			nxt_buf[nxt_bcnt[0]] = pipe_ff[PIPE_DEPTH-1];
			nxt_bcnt = 2'(nxt_bcnt + 2'd1);
		end
		// Valid is registered so the stream pins leave flops
		nxt_vld = (nxt_bcnt != 2'd0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_ff[0] <= '0;
			buf_ff[1] <= '0;
			bcnt_ff   <= '0;
			vld_ff    <= 1'b0;
		end else begin
			buf_ff  <= nxt_buf;
			bcnt_ff <= nxt_bcnt;
			vld_ff  <= nxt_vld;
		end
	end

	assign res_valid = vld_ff;
	assign res_word  = buf_ff[0];

	// APB slave, one wait state
	assign apb_acc = psel && penable && !pready_ff;
	assign hdr_wr  = psel && penable && pwrite && pready_ff;

	always_comb begin
		nxt_ctrl    = ctrl_ff;
		nxt_prdata  = prdata_ff;
		nxt_pslverr = 1'b0;
		nxt_pready  = apb_acc;
		// A write lands only on the edge that completes the transfer
		if (hdr_wr && paddr == CTRL_OFFSET)
			nxt_ctrl = {29'h0, pwdata[2:0]};
		if (apb_acc) begin
			if (paddr == CTRL_OFFSET)
				nxt_prdata = ctrl_ff;
			else if (paddr == STATUS_OFFSET)
				nxt_prdata = {26'h0, state_ff, 2'b00, or_ff, rdy_ff};
			else if (paddr == DATA_OFFSET)
				nxt_prdata = {20'h0, dout_ff};
			else begin
				nxt_prdata  = '0;
				nxt_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= CTRL_RESET;
			prdata_ff  <= '0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

endmodule : pac_core
`default_nettype wire

// ==== core/pac_pkg.sv ====
/*
 * Package for the pipelined converter control and status block:
 * timing counts, state encoding and the output word carrier.
 * Assumes a 50 MHz conversion clock on pclk.
 */
package pac_pkg;

	localparam int          CLK_MHZ          = 50;
	localparam int          DATA_W           = 12;
	// Calibration length in conversion clock cycles
	localparam int          CAL_CYCLES       = 4000;
	// Least calibration request length in cycles
	localparam int          CAL_REQ_CYCLES   = 3;
	// Wake delay in ns, and its cycle count
	localparam int          WAKE_DELAY_NS    = 1000;
	localparam int          WAKE_CYCLES      =
		(WAKE_DELAY_NS * CLK_MHZ) / 1000;
	// Fixed pipeline latency in cycles
	localparam int          PIPE_DEPTH       = 6;
	// APB register offsets
	localparam logic [11:0] CTRL_OFFSET      = 12'h0000;
	localparam logic [11:0] STATUS_OFFSET    = 12'h0004;
	localparam logic [11:0] DATA_OFFSET      = 12'h0008;
	// CTRL fields
	localparam int          CTRL_NOE_BIT     = 0;
	localparam int          CTRL_PD_BIT      = 1;
	localparam int          CTRL_CAL_BIT     = 2;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;
	// STATUS fields
	localparam int          STAT_READY_BIT   = 0;
	localparam int          STAT_OR_BIT      = 1;
	localparam int          STAT_STATE_LSB   = 4;

	typedef enum logic [1:0] {
		ST_CAL  = 2'b00,
		ST_RUN  = 2'b01,
		ST_PD   = 2'b10,
		ST_WAKE = 2'b11
	} pac_state_t;

	typedef struct packed {
		logic              out_of_range;
		logic [DATA_W-1:0] code;
	} pac_word_t;

endpackage : pac_pkg

// ==== testbench/pac_chk.sv ====
/* Checker on the pac_core pins.
 * Assumes a bind from the bench top. */
`timescale 1ns/1ns
`default_nettype none
module pac_chk
	import pac_pkg::*;
(
	// Clock, reset
	input wire logic              pclk,
	input wire logic              presetn,
	// Host pins
	input wire logic              output_enable_n,
	input wire logic              power_down_request,
	input wire logic              cal_request,
	// Outputs
	input wire logic [DATA_W-1:0] data_out,
	input wire logic              data_oe,
	input wire logic              ready_out,
	input wire logic              out_of_range,
	input wire logic              flags_oe,
	input wire logic              res_valid
);
	// Start lag of a calibration is not fixed, so a margin is kept
	logic [12:0] busy_ff, nxt_busy;
	logic [1:0]  req_ff, nxt_req;
	always_comb begin
		nxt_req = {req_ff[0], cal_request};
		nxt_busy = 13'h0000;
		if (busy_ff != 13'h0000)
			nxt_busy = busy_ff - 13'h0001;
		else if (cal_request && req_ff == 2'h3 && ready_out)
			nxt_busy = 13'h0F9B;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_ff <= 13'h0F9B;
			req_ff  <= 2'h0;
		end else begin
			busy_ff <= nxt_busy;
			req_ff  <= nxt_req;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_oe_drive:
	assert property (!output_enable_n[*2] |=> data_oe && flags_oe)
	else $error("outputs not driven");
	a_oe_float:
	assert property (output_enable_n[*2] |=> !data_oe && !flags_oe)
	else $error("outputs not floated");
	a_pd_ready:
	assert property (power_down_request[*2] |=> !ready_out)
	else $error("ready high in power-down");
	a_wake_time:
	assert property ($fell(power_down_request) |-> ##[1:70] ready_out)
	else $error("no wake in time");
	a_wake_blank:
	assert property ($fell(power_down_request) |-> !ready_out[*8])
	else $error("ready during wake");
	a_range_code:
	assert property (out_of_range && ready_out
		|-> data_out == '0 || data_out == 12'hFFF)
	else $error("range code wrong");
	a_cal_busy:
	assert property (busy_ff != 0 && busy_ff < 13'h0F91 |-> !ready_out)
	else $error("ready during calibration");
	a_cal_end:
	assert property (busy_ff == 13'h0001 |-> ##[1:40] ready_out)
	else $error("calibration overran");
	a_stream_on:
	assert property (ready_out[*8] |-> res_valid)
	else $error("result stream stopped");
endmodule : pac_chk
`default_nettype wire

// ==== testbench/pac_host.sv ====
/* Host capture model: takes results unless stalled.
 * Assumes stall is driven right after a clock edge. */
`timescale 1ns/1ns
`default_nettype none
module pac_host
	import pac_pkg::*;
(
	// Clock, reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Stream
	input wire logic       stall,
	input wire logic       res_valid,
	input wire pac_word_t  res_word,
	output logic           res_ready,
	// Capture record
	output logic [15:0]    pop_cnt,
	output pac_word_t      last_word
);
	assign res_ready = !stall;
	// Code and flag taken at one edge, never split
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pop_cnt   <= 16'h0000;
			last_word <= '0;
		end else if (res_valid && res_ready) begin
			pop_cnt   <= pop_cnt + 16'h0001;
			last_word <= res_word;
		end
	end
endmodule : pac_host
`default_nettype wire

// ==== testbench/pipelined_adc_control_status_tb.sv ====
/* Bench for pac_core: boot, registers, pins, range, stream.
 * Assumes pac_pkg, pac_host and pac_chk. */
`timescale 1ns/1ns
`default_nettype none
module pipelined_adc_control_status_tb
	import pac_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic output_enable_n = 0, power_down_request = 0, cal_request = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, data_oe, ready_out, out_of_range, flags_oe, e;
	logic signed [13:0] sample_in = 14'h0064;
	logic [13:0] ref_level = 14'h0FFF;
	logic [DATA_W-1:0] data_out;
	logic res_valid, res_ready, stall = 0;
	pac_word_t res_word, last_word;
	logic [15:0] pop_cnt;
	int mismatches = 0, check_count = 0, n;

	always #10 pclk = ~pclk;

	pac_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .output_enable_n,
		.power_down_request, .cal_request, .sample_in, .ref_level,
		.data_out, .data_oe, .ready_out, .out_of_range, .flags_oe,
		.res_valid, .res_ready, .res_word);
	pac_host host (.pclk, .presetn, .stall, .res_valid, .res_word,
		.res_ready, .pop_cnt, .last_word);

	task automatic finish_test;
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk

	task automatic wait_ready(input int lim);
		n = 0;
		while (ready_out !== 1'b1) begin
			@(posedge pclk);
			n++;
			if (n > lim) begin
				chk(1'b0, "ready timeout");
				finish_test();
			end
		end
	endtask : wait_ready

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			chk(1'b0, "apb timeout");
			finish_test();
		end
	endtask : apb

	task automatic t_regs;
		apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
		chk(q[STAT_READY_BIT] === 1'b1 && e === 1'b0, "status");
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk(e === 1'b1 && q === 32'h0000_0000, "unmapped read");
		apb(1'b1, CTRL_OFFSET, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		chk(ready_out === 1'b0, "ctrl power-down");
		apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
		wait_ready(100);
		chk(n >= 8, "woke too soon");
		apb(1'b1, CTRL_OFFSET, 32'h0000_0004);
		apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
		chk(q === 32'h0000_0004 && e === 1'b0, "ctrl readback");
		repeat (2) @(posedge pclk);
		chk(ready_out === 1'b0, "ctrl calibration");
		apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
		wait_ready(4100);
		chk(n >= 3990, "short ctrl calibration");
	endtask : t_regs

	task automatic t_oe;
		output_enable_n <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(data_oe === 1'b0 && flags_oe === 1'b0, "not floated");
		output_enable_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(data_oe === 1'b1 && flags_oe === 1'b1, "not driven");
	endtask : t_oe

	task automatic t_range;
		logic [13:0] sv [5] = '{14'h3FFF, 14'h0000, 14'h0064, 14'h0FFF,
			14'h1000};
		logic [12:0] ex [5] = '{13'h1000, 13'h0000, 13'h0064, 13'h0FFF,
			13'h1FFF};
		for (int i = 0; i < 5; i++) begin
			sample_in <= sv[i];
			repeat (12) @(posedge pclk);
			chk({out_of_range, data_out} === ex[i], "code");
		end
		sample_in <= 14'h0064;
	endtask : t_range

	task automatic t_stream;
		stall <= 1'b1;
		repeat (3) @(posedge pclk);
		n = pop_cnt;
		repeat (17) @(posedge pclk);
		chk(pop_cnt === n[15:0] && res_valid === 1'b1, "stall");
		stall <= 1'b0;
		repeat (10) @(posedge pclk);
		chk(pop_cnt - n[15:0] >= 16'h0008, "drain");
		chk(last_word === 13'h0064, "word");
	endtask : t_stream

	task automatic t_pd;
		power_down_request <= 1'b1;
		repeat (20) @(posedge pclk);
		chk(ready_out === 1'b0, "ready in power-down");
		power_down_request <= 1'b0;
		wait_ready(100);
		cal_request <= 1'b1;
		repeat (4) @(posedge pclk);
		cal_request <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(ready_out === 1'b0, "no calibration");
		wait_ready(4100);
		chk(n >= 3990, "short calibration");
	endtask : t_pd

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_ready(4200);
		chk(n >= 4000, "short power-on calibration");
		t_regs();
		t_oe();
		t_range();
		t_stream();
		t_pd();
		finish_test();
	end
endmodule : pipelined_adc_control_status_tb

bind pac_core pac_chk u_chk (.pclk, .presetn, .output_enable_n,
	.power_down_request, .cal_request, .data_out, .data_oe, .ready_out,
	.out_of_range, .flags_oe, .res_valid);
`default_nettype wire
